// ==== hw/cmc_defs.svh ====
// What this block does
// - Init request aborts traffic, drops sync, then raises init acknowledge.
// - After init clears, not bus-off: synced after 11 recessive bits.
// - After init clears in bus-off: wait 128 runs of 11 recessive bits.
// - Init request cannot be cleared before init acknowledge is set.
// - Transmit pin goes recessive at once when init is requested.
// - Init request bit: 0 normal operation, 1 initialization mode.
// - Second control register writable only while request and acknowledge set.
// - Module enable write-once in normal mode, repeatable in special mode.
// - Second control bit 7 enables the controller when 1.
// - Second control bit 6: 0 oscillator clock, 1 bus clock.
// - Second control bit 5 loops transmitter stream back to receiver.
// - In loopback receive pin ignored, transmit pin held recessive.
// - In loopback acknowledge slot ignored, own frame accepted as received.
// - In loopback transmit and receive events still raised.
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CMC_OFS_CTL_FIRST  8'h00
`define CMC_OFS_CTL_SECOND 8'h01
`define CMC_OFS_IRQ_STATUS 8'h02
`define CMC_OFS_IRQ_CLEAR  8'h03
`define CMC_OFS_IRQ_ENABLE 8'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMC_BIT_INIT_REQ   0
`define CMC_BIT_SLEEP_REQ  1
`define CMC_BIT_INIT_ACK   0
`define CMC_BIT_SLEEP_ACK  1
`define CMC_BIT_LOOPBACK   5
`define CMC_BIT_CLK_SRC    6
`define CMC_BIT_ENABLE     7

`define CMC_IRQ_INIT_ENTER 0
`define CMC_IRQ_SYNCED     1
`define CMC_IRQ_TX_DONE    2
`define CMC_IRQ_RX_DONE    3
`define CMC_IRQ_BITS       4

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CMC_RST_INIT_REQ   1'b1
`define CMC_RECESSIVE_RUN  11
`define CMC_BUSOFF_RUNS    128
`define CMC_RECESSIVE      1'b1

`endif

// ==== hw/cmc_pkg.sv ====
package cmc_pkg;

  typedef enum logic [1:0] {
    CMC_ST_RUN,
    CMC_ST_ABORT,
    CMC_ST_INIT,
    CMC_ST_SYNC
  } cmc_mode_e;

  // Events reported by the protocol engine
  typedef struct packed {
    logic tx_done;
    logic rx_done;
  } cmc_engine_evt_s;

  // Controls handed to the protocol engine
  typedef struct packed {
    logic abort;
    logic enable;
    logic synced;
    logic loopback;
    logic ack_ignore;
    logic clk_src_bus;
    logic rx_bit;
  } cmc_engine_ctl_s;

endpackage

// ==== hw/cmc_recessive_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"

module cmc_recessive_counter #(
  parameter int RUN_LEN = `CMC_RECESSIVE_RUN,
  parameter int OCC_W   = 8
)(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             clear,
  input  wire logic             bit_tick,
  input  wire logic             rx_bit,
  input  wire logic [OCC_W:0]   target,
  output logic                  done
);

  localparam int RUN_W = $clog2(RUN_LEN + 1);

  logic [RUN_W-1:0] run_reg;
  logic [OCC_W:0]   occ_reg;
  logic             run_full;

  assign run_full = (run_reg == RUN_W'(RUN_LEN - 1));

  // ----------------------------------------------------------------
  // Run of recessive bits; any dominant bit restarts it
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      run_reg <= '0;
    else if (clear)
      run_reg <= '0;
    else if (bit_tick)
    begin
      if (rx_bit != `CMC_RECESSIVE || run_full)
        run_reg <= '0;
      else
        run_reg <= run_reg + RUN_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Occurrences of full runs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      occ_reg <= '0;
    else if (clear)
      occ_reg <= '0;
    else if (bit_tick && rx_bit == `CMC_RECESSIVE && run_full && !done)
      occ_reg <= occ_reg + (OCC_W+1)'(1);
  end

  assign done = (occ_reg >= target) && (target != '0);

endmodule
`default_nettype wire

// ==== hw/cmc_mode_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"

module cmc_mode_control (
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  // Register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [7:0]                    reg_rdata,
  // System and protocol engine side
  input  wire logic                     special_mode,
  input  wire logic                     bus_off,
  input  wire logic                     bus_idle,
  input  wire logic                     bit_tick,
  input  wire logic                     engine_tx_bit,
  input  wire cmc_pkg::cmc_engine_evt_s engine_evt,
  output cmc_pkg::cmc_engine_ctl_s      engine_ctl,
  // Pins
  input  wire logic                     bus_rx_pin,
  output logic                          bus_tx_pin,
  output logic                          irq
);

  import cmc_pkg::*;

  localparam int OCC_W = 8;

  cmc_mode_e         mode_reg;
  cmc_mode_e         mode_next;
  logic              init_request_reg;
  logic              init_request_next;
  logic              init_ack_reg;
  logic              sleep_request_reg;
  logic              sleep_ack_reg;
  logic              module_enable_reg;
  logic              enable_written_reg;
  logic              clock_source_select_reg;
  logic              loopback_select_reg;
  logic              synced_reg;
  logic              abort_reg;
  logic              rx_meta_reg;
  logic              rx_sync_reg;
  logic              rx_bit;
  logic              tx_next;
  logic [OCC_W:0]    target_reg;
  logic              sync_done;
  logic              in_init;
  logic [`CMC_IRQ_BITS-1:0] status_reg;
  logic [`CMC_IRQ_BITS-1:0] enable_reg;
  logic [`CMC_IRQ_BITS-1:0] event_set;
  logic [`CMC_IRQ_BITS-1:0] event_clr;
  logic [7:0]        rdata_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic wr_first;
  logic wr_second;
  logic wr_clear;
  logic wr_enable;

  assign wr_first  = reg_wr && hit(reg_addr, `CMC_OFS_CTL_FIRST);
  assign wr_second = reg_wr && hit(reg_addr, `CMC_OFS_CTL_SECOND);
  assign wr_clear  = reg_wr && hit(reg_addr, `CMC_OFS_IRQ_CLEAR);
  assign wr_enable = reg_wr && hit(reg_addr, `CMC_OFS_IRQ_ENABLE);

  assign in_init = init_request_reg && init_ack_reg;

  // ----------------------------------------------------------------
  // Receive pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_meta_reg <= `CMC_RECESSIVE;
      rx_sync_reg <= `CMC_RECESSIVE;
    end
    else
    begin
      rx_meta_reg <= bus_rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Loopback feeds the engine its own stream; pin is ignored
  assign rx_bit = loopback_select_reg ? engine_tx_bit : rx_sync_reg;

  // ----------------------------------------------------------------
  // Init request
  // ----------------------------------------------------------------
  always_comb
  begin
    init_request_next = init_request_reg;
    if (wr_first)
    begin
      if (reg_wdata[`CMC_BIT_INIT_REQ])
        init_request_next = 1'b1;
      else if (init_ack_reg)
        init_request_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      init_request_reg <= `CMC_RST_INIT_REQ;
    else
      init_request_reg <= init_request_next;
  end

  // ----------------------------------------------------------------
  // Sleep request, acknowledged once the bus is idle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_request_reg <= 1'b0;
      sleep_ack_reg     <= 1'b0;
    end
    else
    begin
      if (wr_first)
      begin
        if (reg_wdata[`CMC_BIT_SLEEP_REQ])
          sleep_request_reg <= 1'b1;
        else if (sleep_ack_reg)
          sleep_request_reg <= 1'b0;
      end
      sleep_ack_reg <= sleep_request_reg && (bus_idle || sleep_ack_reg);
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      CMC_ST_RUN:
        if (init_request_reg)
          mode_next = CMC_ST_ABORT;
      CMC_ST_ABORT:
        mode_next = CMC_ST_INIT;
      CMC_ST_INIT:
        if (!init_request_reg)
          mode_next = CMC_ST_SYNC;
      CMC_ST_SYNC:
        if (init_request_reg)
          mode_next = CMC_ST_ABORT;
        else if (sync_done)
          mode_next = CMC_ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_reg <= CMC_ST_INIT;
    else
      mode_reg <= mode_next;
  end

  // Acknowledge tracks the init state both ways
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      init_ack_reg <= `CMC_RST_INIT_REQ;
    else
      init_ack_reg <= (mode_next == CMC_ST_INIT);
  end

  // One-cycle abort to the engine, sync dropped with it
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      abort_reg  <= 1'b0;
      synced_reg <= 1'b0;
    end
    else
    begin
      abort_reg <= (mode_next == CMC_ST_ABORT);
      if (mode_next == CMC_ST_RUN)
        synced_reg <= 1'b1;
      else
        synced_reg <= 1'b0;
    end
  end

  // Bus-off state is sampled when init is left
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      target_reg <= (OCC_W+1)'(1);
    else if (mode_reg == CMC_ST_INIT && !init_request_reg)
      target_reg <= bus_off ? (OCC_W+1)'(`CMC_BUSOFF_RUNS)
                            : (OCC_W+1)'(1);
  end

  cmc_recessive_counter #(
    .RUN_LEN (`CMC_RECESSIVE_RUN),
    .OCC_W   (OCC_W)
  ) u_run (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .clear    (mode_reg != CMC_ST_SYNC),
    .bit_tick (bit_tick && module_enable_reg),
    .rx_bit   (rx_bit),
    .target   (target_reg),
    .done     (sync_done)
  );

  // ----------------------------------------------------------------
  // Second control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clock_source_select_reg <= 1'b0;
      loopback_select_reg     <= 1'b0;
    end
    else if (wr_second && in_init)
    begin
      clock_source_select_reg <= reg_wdata[`CMC_BIT_CLK_SRC];
      loopback_select_reg     <= reg_wdata[`CMC_BIT_LOOPBACK];
    end
  end

  // Enable takes one write per reset unless in special mode
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      module_enable_reg  <= 1'b0;
      enable_written_reg <= 1'b0;
    end
    else if (wr_second && in_init &&
             (special_mode || !enable_written_reg))
    begin
      module_enable_reg  <= reg_wdata[`CMC_BIT_ENABLE];
      enable_written_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit pin
  // ----------------------------------------------------------------
  // Uses the request's next value so the pin goes recessive on the
  // edge that takes the write, not one cycle later.
  always_comb
  begin
    if (init_request_next || loopback_select_reg || !module_enable_reg)
      tx_next = `CMC_RECESSIVE;
    else
      tx_next = engine_tx_bit;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      bus_tx_pin <= `CMC_RECESSIVE;
    else
      bus_tx_pin <= tx_next;
  end

  // ----------------------------------------------------------------
  // Engine controls
  // ----------------------------------------------------------------
  always_comb
  begin
    engine_ctl             = '0;
    engine_ctl.abort       = abort_reg;
    engine_ctl.enable      = module_enable_reg;
    engine_ctl.synced      = synced_reg;
    engine_ctl.loopback    = loopback_select_reg;
    engine_ctl.ack_ignore  = loopback_select_reg;
    engine_ctl.clk_src_bus = clock_source_select_reg;
    engine_ctl.rx_bit      = rx_bit;
  end

  // ----------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------
  // Frame events pass in loopback exactly as on the bus
  always_comb
  begin
    event_set = '0;
    event_set[`CMC_IRQ_INIT_ENTER] = (mode_next == CMC_ST_INIT) &&
                                     !init_ack_reg;
    event_set[`CMC_IRQ_SYNCED]     = (mode_reg == CMC_ST_SYNC) &&
                                     (mode_next == CMC_ST_RUN);
    event_set[`CMC_IRQ_TX_DONE]    = engine_evt.tx_done;
    event_set[`CMC_IRQ_RX_DONE]    = engine_evt.rx_done;
  end

  assign event_clr = wr_clear ? reg_wdata[`CMC_IRQ_BITS-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~event_clr) | event_set;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      enable_reg <= '0;
    else if (wr_enable)
      enable_reg <= reg_wdata[`CMC_IRQ_BITS-1:0];
  end

  assign irq = |(status_reg & enable_reg);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_reg = '0;
    if (hit(reg_addr, `CMC_OFS_CTL_FIRST))
    begin
      rdata_reg[`CMC_BIT_INIT_REQ]  = init_request_reg;
      rdata_reg[`CMC_BIT_SLEEP_REQ] = sleep_request_reg;
    end
    else if (hit(reg_addr, `CMC_OFS_CTL_SECOND))
    begin
      rdata_reg[`CMC_BIT_ENABLE]    = module_enable_reg;
      rdata_reg[`CMC_BIT_CLK_SRC]   = clock_source_select_reg;
      rdata_reg[`CMC_BIT_LOOPBACK]  = loopback_select_reg;
      rdata_reg[`CMC_BIT_SLEEP_ACK] = sleep_ack_reg;
      rdata_reg[`CMC_BIT_INIT_ACK]  = init_ack_reg;
    end
    else if (hit(reg_addr, `CMC_OFS_IRQ_STATUS))
      rdata_reg[`CMC_IRQ_BITS-1:0] = status_reg;
    else if (hit(reg_addr, `CMC_OFS_IRQ_ENABLE))
      rdata_reg[`CMC_IRQ_BITS-1:0] = enable_reg;
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rdata_reg;
    else
      reg_rdata <= '0;
  end

endmodule
`default_nettype wire

// ==== test/cmc_mode_control_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"

module cmc_mode_control_properties (
  input wire logic                     ref_clk,
  input wire logic                     arst_n,
  input wire logic [7:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     bus_off,
  input wire logic                     bit_tick,
  input wire logic                     engine_tx_bit,
  input wire cmc_pkg::cmc_engine_ctl_s engine_ctl,
  input wire logic                     bus_tx_pin,
  input wire logic                     irq
);
  import cmc_pkg::*;

  localparam int BUSOFF_TICKS = `CMC_BUSOFF_RUNS * `CMC_RECESSIVE_RUN;
  logic [11:0] rec_cnt_reg;

  // Lower bound only: ticks seen while disabled are counted as well
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rec_cnt_reg <= 12'h000;
    else if (engine_ctl.abort || (bit_tick && !engine_ctl.rx_bit))
      rec_cnt_reg <= 12'h000;
    else if (bit_tick && rec_cnt_reg != 12'hFFF)
      rec_cnt_reg <= rec_cnt_reg + 12'h001;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_tx_on_init: assert property (
    reg_wr && reg_addr == `CMC_OFS_CTL_FIRST &&
    reg_wdata[`CMC_BIT_INIT_REQ] |=> bus_tx_pin)
    else $error("tx pin not recessive after init request");
  a_abort_unsync: assert property (
    $rose(engine_ctl.abort) |-> bus_tx_pin ##2 !engine_ctl.synced)
    else $error("sync kept after abort");
  a_loop_tx_idle: assert property (
    engine_ctl.loopback && $past(engine_ctl.loopback) |-> bus_tx_pin)
    else $error("tx pin driven during loopback");
  a_loop_rx_route: assert property (
    engine_ctl.loopback |-> engine_ctl.rx_bit == engine_tx_bit)
    else $error("receiver not fed from transmitter");
  // Ack slot handling may only move on a write to the second control
  a_ack_ignore: assert property (
    engine_ctl.ack_ignore == engine_ctl.loopback &&
    (!$changed(engine_ctl.ack_ignore) ||
     $past(reg_wr && reg_addr == `CMC_OFS_CTL_SECOND)))
    else $error("ack slot handling differs from loopback");
  a_off_tx_idle: assert property (
    !engine_ctl.enable && !$past(engine_ctl.enable) |-> bus_tx_pin)
    else $error("tx pin driven while disabled");
  a_sync_run: assert property (
    $rose(engine_ctl.synced) |-> rec_cnt_reg >= `CMC_RECESSIVE_RUN)
    else $error("synced before a full recessive run");
  a_busoff_wait: assert property (
    $rose(engine_ctl.synced) && bus_off |-> rec_cnt_reg >= BUSOFF_TICKS)
    else $error("bus-off wait cut short");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  c_abort: cover property ($rose(engine_ctl.abort));
  c_synced: cover property ($rose(engine_ctl.synced));
  c_loop_irq: cover property (irq && engine_ctl.loopback);
endmodule

bind cmc_mode_control cmc_mode_control_properties u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_off(bus_off), .bit_tick(bit_tick),
  .engine_tx_bit(engine_tx_bit), .engine_ctl(engine_ctl),
  .bus_tx_pin(bus_tx_pin), .irq(irq)
);
`default_nettype wire

// ==== test/cmc_bus_node.sv ====
`timescale 1ns/1ps
`default_nettype none

// Transceiver plus remote nodes: dominant (0) wins on the wire
module cmc_bus_node (
  input  wire logic ref_clk,
  input  wire logic bus_tx_pin,
  input  wire logic remote_dominant,
  output logic      bus_rx_pin
);
  // One cycle of loop delay through the transceiver
  always_ff @(posedge ref_clk)
    bus_rx_pin <= bus_tx_pin & !remote_dominant;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"

`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module testbench;
  import cmc_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } cmc_row_s;

  logic            ref_clk         = 1'b0;
  logic            arst_n          = 1'b0;
  logic [7:0]      reg_addr        = 8'h00;
  logic [7:0]      reg_wdata       = 8'h00;
  logic            reg_wr          = 1'b0;
  logic            reg_rd          = 1'b0;
  logic [7:0]      reg_rdata;
  logic            special_mode    = 1'b0;
  logic            bus_off         = 1'b0;
  logic            bit_tick        = 1'b0;
  logic            engine_tx_bit   = 1'b1;
  logic            remote_dominant = 1'b0;
  logic            bus_rx_pin;
  logic            bus_tx_pin;
  logic            irq;
  cmc_engine_evt_s engine_evt      = '0;
  cmc_engine_ctl_s engine_ctl;
  int              bad_count       = 0;
  int              samples_checked = 0;
  // Enable stays set once written; later writes only touch bits 6:5
  cmc_row_s        rows [5]        = '{
    '{8'h01, 8'hA0, 8'hA1}, '{8'h01, 8'h20, 8'hA1},
    '{8'h01, 8'h60, 8'hE1}, '{8'h04, 8'h0F, 8'h0F},
    '{8'h05, 8'h55, 8'h00}};

  always #10 ref_clk = ~ref_clk;

  cmc_mode_control DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_mode(special_mode),
    .bus_off(bus_off), .bus_idle(1'b1), .bit_tick(bit_tick),
    .engine_tx_bit(engine_tx_bit), .engine_evt(engine_evt),
    .engine_ctl(engine_ctl), .bus_rx_pin(bus_rx_pin),
    .bus_tx_pin(bus_tx_pin), .irq(irq)
  );

  cmc_bus_node u_node (
    .ref_clk(ref_clk), .bus_tx_pin(bus_tx_pin),
    .remote_dominant(remote_dominant), .bus_rx_pin(bus_rx_pin)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  // Second data word lands on the very next edge, strobe held high
  task automatic wr2(input logic [7:0] a, input logic [7:0] d1,
                     input logic [7:0] d2);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d1;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wdata <= d2;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex,
                        input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
  endtask

  // Recessive level must settle through the synchroniser before a tick
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      bit_tick <= 1'b1;
      @(posedge ref_clk);
      bit_tick <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (7) @(posedge ref_clk);
    #1;
    `CHK("tx_rst", 1'b1, bus_tx_pin)
    `CHK("irq_rst", 1'b0, irq)
    @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(`CMC_OFS_CTL_FIRST, 8'h01, "ctl1_rst");
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h01, "ctl2_rst");
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].rdata, "row");
    end
    `CHK("enable", 1'b1, engine_ctl.enable)
    `CHK("clk_src", 1'b1, engine_ctl.clk_src_bus)
    wr(`CMC_OFS_IRQ_CLEAR, 8'hFF);
    @(posedge ref_clk);
    engine_tx_bit   <= 1'b0;
    remote_dominant <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    `CHK("lb_rx0", 1'b0, engine_ctl.rx_bit)
    `CHK("lb_tx", 1'b1, bus_tx_pin)
    `CHK("lb_ack", 1'b1, engine_ctl.ack_ignore)
    @(posedge ref_clk);
    engine_tx_bit <= 1'b1;
    engine_evt    <= 2'b11;
    @(posedge ref_clk);
    engine_evt    <= 2'b00;
    step();
    `CHK("lb_rx1", 1'b1, engine_ctl.rx_bit)
    `CHK("irq_on", 1'b1, irq)
    rd_chk(`CMC_OFS_IRQ_STATUS, 8'h0C, "events");
    wr(`CMC_OFS_IRQ_ENABLE, 8'h00);
    step();
    `CHK("irq_mask", 1'b0, irq)
    wr(`CMC_OFS_IRQ_ENABLE, 8'h0F);
    step();
    `CHK("irq_unmask", 1'b1, irq)
    wr(`CMC_OFS_IRQ_CLEAR, 8'h0C);
    step();
    `CHK("irq_clr", 1'b0, irq)
    @(posedge ref_clk);
    remote_dominant <= 1'b0;
    wr(`CMC_OFS_CTL_SECOND, 8'h80);
    wr(`CMC_OFS_CTL_FIRST, 8'h00);
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h80, "ack_clr");
    wr(`CMC_OFS_CTL_SECOND, 8'hC0);
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h80, "ctl2_lock");
    ticks(5);
    @(posedge ref_clk);
    remote_dominant <= 1'b1;
    repeat (5) @(posedge ref_clk);
    ticks(1);
    @(posedge ref_clk);
    remote_dominant <= 1'b0;
    repeat (5) @(posedge ref_clk);
    ticks(10);
    #1;
    `CHK("sync_early", 1'b0, engine_ctl.synced)
    ticks(1);
    step();
    `CHK("sync_done", 1'b1, engine_ctl.synced)
    @(posedge ref_clk);
    engine_tx_bit <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("tx_run", 1'b0, bus_tx_pin)
    // Sleep first, written while outside init; it stays set from here on
    wr(`CMC_OFS_CTL_FIRST, 8'h02);
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h82, "sleep_ack");
    wr2(`CMC_OFS_CTL_FIRST, 8'h03, 8'h02);
    #1;
    `CHK("tx_init", 1'b1, bus_tx_pin)
    rd_chk(`CMC_OFS_CTL_FIRST, 8'h03, "early_clr");
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h83, "ack_set");
    `CHK("sync_lost", 1'b0, engine_ctl.synced)
    @(posedge ref_clk);
    bus_off       <= 1'b1;
    engine_tx_bit <= 1'b1;
    wr(`CMC_OFS_CTL_FIRST, 8'h02);
    ticks(1407);
    #1;
    `CHK("boff_early", 1'b0, engine_ctl.synced)
    ticks(1);
    step();
    `CHK("boff_done", 1'b1, engine_ctl.synced)
    rd_chk(`CMC_OFS_IRQ_STATUS, 8'h03, "mode_evts");
    wr(`CMC_OFS_CTL_FIRST, 8'h03);
    repeat (4) @(posedge ref_clk);
    special_mode <= 1'b1;
    wr(`CMC_OFS_CTL_SECOND, 8'h00);
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h03, "sp_off");
    wr(`CMC_OFS_CTL_SECOND, 8'h80);
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h83, "sp_on");
    @(posedge ref_clk);
    special_mode <= 1'b0;
    wr(`CMC_OFS_CTL_SECOND, 8'h00);
    rd_chk(`CMC_OFS_CTL_SECOND, 8'h83, "once");
    summarize();
  end
endmodule
`default_nettype wire
